// *** design/ttc_channel.sv ***
// timer channel one: count source, edge select, clear select, mode and register A I/O
`timescale 1ns/1ns
`default_nettype none
module ttc_channel (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [ttc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ttc_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ttc_pkg::DATA_W-1:0] rd_data_o,
    input wire logic channel_one_pin_a_i,
    input wire logic clk_pin_a_i,
    input wire logic clk_pin_b_i,
    input wire logic neighbour_ovf_i,
    input wire logic sync_clear_i,
    input wire logic ch0_gra_event_i,
    output logic channel_one_pin_a_o,
    output logic channel_one_pin_a_oe_o,
    output logic ovf_o,
    output logic sync_clear_o
);
    ttc_pkg::ttc_ctrl_type ctrl_reg;
    logic [3:0] mode_reg;
    logic [7:0] io_ctrl_reg;
    logic sync_en_reg;
    logic [15:0] channel_counter_reg;
    logic [15:0] channel_counter_next;
    logic [15:0] general_reg_a_reg;
    logic [15:0] general_reg_b_reg;
    logic counted_reg;
    logic pin_reg;
    logic pin_oe_reg;
    logic [15:0] rd_data_reg;
    logic ovf_reg;
    logic sync_clear_reg;
    ttc_pkg::ttc_pins_type pins;
    ttc_pkg::ttc_taps_type taps;

    // edge choice shared by prescaled and pin clocks
    function automatic logic edge_pick(input logic r, input logic f, input logic [1:0] sel);
        edge_pick = sel[1] ? (r | f) : ((sel == ttc_pkg::EDGE_FALL) ? f : r);
    endfunction : edge_pick

    ttc_pin_sync u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i({clk_pin_b_i, clk_pin_a_i, channel_one_pin_a_i}),
        .pins_o(pins)
    );

    ttc_prescaler #(
        .WIDTH(ttc_pkg::PRESCALE_W)
    ) u_prescaler (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .taps_o(taps)
    );

    // register port decode
    wire wr_ctrl = wr_i && (addr_i == ttc_pkg::ADDR_CTRL);
    wire wr_mode = wr_i && (addr_i == ttc_pkg::ADDR_MODE);
    wire wr_io = wr_i && (addr_i == ttc_pkg::ADDR_IOCTRL);
    wire wr_sync = wr_i && (addr_i == ttc_pkg::ADDR_SYNC);
    wire wr_cnt = wr_i && (addr_i == ttc_pkg::ADDR_COUNTER);
    wire wr_gra = wr_i && (addr_i == ttc_pkg::ADDR_GRA);
    wire wr_grb = wr_i && (addr_i == ttc_pkg::ADDR_GRB);

    // mode decode; the reserved top bit set leaves the channel in normal counting
    wire phase_mode = (mode_reg[3:2] == 2'h1);
    wire [3:0] io_a = io_ctrl_reg[3:0];
    wire oc_mode = !io_a[3];
    wire ch0_capture = io_a[3] && io_a[2];

    // count source; /1 and neighbour overflow count every tick whatever the edge code
    logic src_tick;
    always_comb begin
        unique case (ctrl_reg.source_sel)
            ttc_pkg::SRC_DIV1: src_tick = 1'b1;
            ttc_pkg::SRC_DIV4: src_tick = edge_pick(taps.rise[0], taps.fall[0],
                                                    ctrl_reg.edge_sel);
            ttc_pkg::SRC_DIV16: src_tick = edge_pick(taps.rise[1], taps.fall[1],
                                                     ctrl_reg.edge_sel);
            ttc_pkg::SRC_DIV64: src_tick = edge_pick(taps.rise[2], taps.fall[2],
                                                     ctrl_reg.edge_sel);
            ttc_pkg::SRC_DIV256: src_tick = edge_pick(taps.rise[3], taps.fall[3],
                                                      ctrl_reg.edge_sel);
            ttc_pkg::SRC_PIN_A: src_tick = edge_pick(pins.rise[ttc_pkg::PIN_CLK_A],
                                                     pins.fall[ttc_pkg::PIN_CLK_A],
                                                     ctrl_reg.edge_sel);
            ttc_pkg::SRC_PIN_B: src_tick = edge_pick(pins.rise[ttc_pkg::PIN_CLK_B],
                                                     pins.fall[ttc_pkg::PIN_CLK_B],
                                                     ctrl_reg.edge_sel);
            ttc_pkg::SRC_NEIGHBOUR: src_tick = neighbour_ovf_i;
        endcase
    end

    // quadrature decode for phase counting; edge and source codes play no part
    wire a_edge = pins.rise[ttc_pkg::PIN_CLK_A] | pins.fall[ttc_pkg::PIN_CLK_A];
    wire b_edge = pins.rise[ttc_pkg::PIN_CLK_B] | pins.fall[ttc_pkg::PIN_CLK_B];
    wire ab_differ = pins.level[ttc_pkg::PIN_CLK_A] ^ pins.level[ttc_pkg::PIN_CLK_B];
    wire phase_up = (a_edge && ab_differ) || (b_edge && !ab_differ);
    wire phase_down = (a_edge && !ab_differ) || (b_edge && ab_differ);
    wire count_up = phase_mode ? phase_up : src_tick;
    wire count_down = phase_mode && phase_down && !phase_up;

    // compare matches are taken once, on the cycle after the counter moved onto the value
    wire match_a = counted_reg && (channel_counter_reg == general_reg_a_reg);
    wire match_b = counted_reg && (channel_counter_reg == general_reg_b_reg);

    // capture sources for register A
    wire pin_cap_rise = pins.rise[ttc_pkg::PIN_CAP];
    wire pin_cap_fall = pins.fall[ttc_pkg::PIN_CAP];
    wire pin_capture = io_a[3] && !io_a[2]
                       && edge_pick(pin_cap_rise, pin_cap_fall, io_a[1:0]);
    wire capture_a = pin_capture || (ch0_capture && ch0_gra_event_i);
    wire event_a = (oc_mode && match_a) || capture_a;

    // clear select
    logic clear_hit;
    always_comb begin
        unique case (ctrl_reg.clear_sel)
            ttc_pkg::CLR_NONE: clear_hit = 1'b0;
            ttc_pkg::CLR_GRA: clear_hit = event_a;
            ttc_pkg::CLR_GRB: clear_hit = match_b;
            ttc_pkg::CLR_SYNC: clear_hit = sync_clear_i;
        endcase
    end

    // counter next value; a software write beats a clear, a clear beats counting
    wire wraps_up = count_up && (channel_counter_reg == ttc_pkg::MAX16);
    wire wraps_down = count_down && (channel_counter_reg == ttc_pkg::ZERO16);
    always_comb begin
        if (wr_cnt) begin
            channel_counter_next = wr_data_i;
        end else if (clear_hit) begin
            channel_counter_next = ttc_pkg::ZERO16;
        end else if (count_up) begin
            channel_counter_next = channel_counter_reg + ttc_pkg::ONE16;
        end else if (count_down) begin
            channel_counter_next = channel_counter_reg - ttc_pkg::ONE16;
        end else begin
            channel_counter_next = channel_counter_reg;
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= '0;
            mode_reg <= 4'h0;
            io_ctrl_reg <= 8'h00;
            sync_en_reg <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_reg <= wr_data_i[6:0];
            if (wr_mode) mode_reg <= wr_data_i[3:0]; // top bit stored as written
            if (wr_io) io_ctrl_reg <= wr_data_i[7:0];
            if (wr_sync) sync_en_reg <= wr_data_i[0];
        end
    end

    // counter and general registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            channel_counter_reg <= ttc_pkg::ZERO16;
            counted_reg <= 1'b0;
            general_reg_a_reg <= ttc_pkg::MAX16;
            general_reg_b_reg <= ttc_pkg::MAX16;
        end else begin
            channel_counter_reg <= channel_counter_next;
            counted_reg <= !wr_cnt && !clear_hit && (count_up || count_down);
            if (capture_a) begin
                general_reg_a_reg <= channel_counter_reg;
            end else if (wr_gra) begin
                general_reg_a_reg <= wr_data_i;
            end
            if (wr_grb) general_reg_b_reg <= wr_data_i;
        end
    end

    // pin drive: the write sets the start level at once, a match then acts on it
    wire io_wr_is_oc = !wr_data_i[3];
    wire pin_on_match = (io_a[1:0] == 2'h3) ? !pin_reg : io_a[1];
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pin_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else if (wr_io) begin
            pin_reg <= io_wr_is_oc && wr_data_i[2];
            pin_oe_reg <= io_wr_is_oc && (wr_data_i[1:0] != 2'h0);
        end else if (oc_mode && match_a && pin_oe_reg) begin
            pin_reg <= pin_on_match;
        end
    end

    // overflow/underflow and synchronous clear towards the neighbours
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ovf_reg <= 1'b0;
            sync_clear_reg <= 1'b0;
        end else begin
            ovf_reg <= !wr_cnt && !clear_hit && (wraps_up || wraps_down);
            sync_clear_reg <= sync_en_reg && clear_hit
                              && (ctrl_reg.clear_sel != ttc_pkg::CLR_SYNC);
        end
    end

    // read mux; unmapped bits read zero except the fixed upper mode bits, which read one; the status word shows the pin state
    logic [15:0] rd_mux;
    always_comb begin
        unique case (addr_i)
            ttc_pkg::ADDR_CTRL: rd_mux = {9'h000, ctrl_reg};
            ttc_pkg::ADDR_MODE: rd_mux = {8'h00, ttc_pkg::MODE_FIXED_ONES | {4'h0, mode_reg}};
            ttc_pkg::ADDR_IOCTRL: rd_mux = {8'h00, io_ctrl_reg};
            ttc_pkg::ADDR_SYNC: rd_mux = {15'h0000, sync_en_reg};
            ttc_pkg::ADDR_COUNTER: rd_mux = channel_counter_reg;
            ttc_pkg::ADDR_GRA: rd_mux = general_reg_a_reg;
            ttc_pkg::ADDR_GRB: rd_mux = general_reg_b_reg;
            ttc_pkg::ADDR_STATUS: rd_mux = {13'h0000, phase_mode, pin_oe_reg, pin_reg};
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_data_reg <= ttc_pkg::ZERO16;
        end else begin
            rd_data_reg <= rd_i ? rd_mux : ttc_pkg::ZERO16;
        end
    end

    assign rd_data_o = rd_data_reg;
    assign channel_one_pin_a_o = pin_reg;
    assign channel_one_pin_a_oe_o = pin_oe_reg;
    assign ovf_o = ovf_reg;
    assign sync_clear_o = sync_clear_reg;

    // checks
    wire quiet = !wr_cnt && (ctrl_reg.clear_sel == ttc_pkg::CLR_NONE);
    AST_EDGE_FALL_DIV4: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (quiet && !phase_mode && ctrl_reg.source_sel == ttc_pkg::SRC_DIV4
         && ctrl_reg.edge_sel == ttc_pkg::EDGE_FALL && taps.rise[0])
        |=> channel_counter_reg == $past(channel_counter_reg))
        else $error("counter moved on a rising edge with falling edge selected");
    AST_PHASE_IGNORES_EDGE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (quiet && phase_mode && !a_edge && !b_edge) |=> $stable(channel_counter_reg))
        else $error("phase counting moved without a pin edge");
    AST_DIV1_EVERY_CYCLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (quiet && !phase_mode && ctrl_reg.source_sel == ttc_pkg::SRC_DIV1)[*2]
        |=> channel_counter_reg == $past(channel_counter_reg, 2) + 16'h0002)
        else $error("undivided source did not count each cycle");
    AST_CLEAR_ON_A: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!wr_cnt && ctrl_reg.clear_sel == ttc_pkg::CLR_GRA && event_a)
        |=> channel_counter_reg == ttc_pkg::ZERO16)
        else $error("register A event did not clear the counter");
    AST_CLEAR_SYNC: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!wr_cnt && ctrl_reg.clear_sel == ttc_pkg::CLR_SYNC && sync_clear_i)
        |=> channel_counter_reg == ttc_pkg::ZERO16)
        else $error("synchronous clear was missed");
    AST_MODE_DECODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_mode ##1 (1'b1) |-> phase_mode == ($past(wr_data_i[3:2]) == 2'h1))
        else $error("phase mode decode wrong after mode write");
    AST_MATCH_LOW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!wr_io && pin_oe_reg && oc_mode && io_a[1:0] == 2'h1 && match_a)
        |=> !channel_one_pin_a_o ##1 (!channel_one_pin_a_o || $past(wr_io)))
        else $error("pin not low after match in low-on-match code");
    AST_MATCH_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!wr_io && pin_oe_reg && oc_mode && io_a[1:0] == 2'h2 && match_a)
        |=> channel_one_pin_a_o)
        else $error("pin not high after match in high-on-match code");
    AST_TOGGLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!wr_io && oc_mode && io_a[1:0] == 2'h3 && match_a)
        |=> channel_one_pin_a_o != $past(channel_one_pin_a_o))
        else $error("pin did not toggle on match");
    AST_PIN_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (io_a == 4'h8 && pin_cap_rise) |=> general_reg_a_reg == $past(channel_counter_reg))
        else $error("rising pin edge not captured");
    AST_CH0_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (ch0_capture && ch0_gra_event_i) |=> general_reg_a_reg == $past(channel_counter_reg))
        else $error("channel zero event not captured");
    AST_INITIAL_LEVEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_io && !wr_data_i[3])
        |=> channel_one_pin_a_o == $past(wr_data_i[2])
            && channel_one_pin_a_oe_o == ($past(wr_data_i[1:0]) != 2'h0))
        else $error("initial pin level not applied on write");
endmodule : ttc_channel
`default_nettype wire

// *** design/ttc_pkg.sv ***
// shared constants, encodings and carriers for the timer channel one control block
package ttc_pkg;
    // register indices on the plain register port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_MODE = 3'h1;
    localparam logic [2:0] ADDR_IOCTRL = 3'h2;
    localparam logic [2:0] ADDR_SYNC = 3'h3;
    localparam logic [2:0] ADDR_COUNTER = 3'h4;
    localparam logic [2:0] ADDR_GRA = 3'h5;
    localparam logic [2:0] ADDR_GRB = 3'h6;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    // fixed upper bits of the mode register read back as ones
    localparam logic [7:0] MODE_FIXED_ONES = 8'hc0;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [15:0] MAX16 = 16'hffff;
    // counter clear sources
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_GRA = 2'h1;
    localparam logic [1:0] CLR_GRB = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;
    // count edge codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    // count source codes
    localparam logic [2:0] SRC_DIV1 = 3'h0;
    localparam logic [2:0] SRC_DIV4 = 3'h1;
    localparam logic [2:0] SRC_DIV16 = 3'h2;
    localparam logic [2:0] SRC_DIV64 = 3'h3;
    localparam logic [2:0] SRC_PIN_A = 3'h4;
    localparam logic [2:0] SRC_PIN_B = 3'h5;
    localparam logic [2:0] SRC_DIV256 = 3'h6;
    localparam logic [2:0] SRC_NEIGHBOUR = 3'h7;
    // prescaler taps (bit index of free counter) for /4, /16, /64, /256
    localparam int TAP_N = 4;
    localparam int PRESCALE_W = 8;
    // synchronised pin indices
    localparam int PIN_N = 3;
    localparam int PIN_CAP = 0;
    localparam int PIN_CLK_A = 1;
    localparam int PIN_CLK_B = 2;
    // count source and clear control as stored in the control register
    typedef struct packed {
        logic [1:0] clear_sel;
        logic [1:0] edge_sel;
        logic [2:0] source_sel;
    } ttc_ctrl_type;
    // synchronised pin view: level and one-cycle edge pulses
    typedef struct packed {
        logic [PIN_N-1:0] level;
        logic [PIN_N-1:0] rise;
        logic [PIN_N-1:0] fall;
    } ttc_pins_type;
    // prescaler edge pulses of each divided clock
    typedef struct packed {
        logic [TAP_N-1:0] rise;
        logic [TAP_N-1:0] fall;
    } ttc_taps_type;
endpackage : ttc_pkg

// *** design/ttc_pin_sync.sv ***
// two-stage synchroniser with edge detection for the channel pins
`timescale 1ns/1ns
`default_nettype none
module ttc_pin_sync (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [ttc_pkg::PIN_N-1:0] pin_i,
    output ttc_pkg::ttc_pins_type pins_o
);
    logic [ttc_pkg::PIN_N-1:0] meta_reg;
    logic [ttc_pkg::PIN_N-1:0] sync_reg;
    logic [ttc_pkg::PIN_N-1:0] prev_reg;

    // first stage feeds only the second; edges look at stages two and three
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // edge pulses last one cycle
    assign pins_o.level = sync_reg;
    assign pins_o.rise = sync_reg & ~prev_reg;
    assign pins_o.fall = ~sync_reg & prev_reg;
endmodule : ttc_pin_sync
`default_nettype wire

// *** design/ttc_prescaler.sv ***
// free-running prescaler giving edge pulses of the divided clocks
`timescale 1ns/1ns
`default_nettype none
module ttc_prescaler #(
    parameter int WIDTH = ttc_pkg::PRESCALE_W
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    output ttc_pkg::ttc_taps_type taps_o
);
    logic [WIDTH-1:0] div_reg;
    logic [WIDTH-1:0] div_prev_reg;
    logic [ttc_pkg::TAP_N-1:0] tap_now;
    logic [ttc_pkg::TAP_N-1:0] tap_old;

    // the divided clocks are simply the odd counter bits
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            div_reg <= '0;
            div_prev_reg <= '0;
        end else begin
            div_reg <= div_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            div_prev_reg <= div_reg;
        end
    end

    // taps 1, 3, 5, 7 give /4, /16, /64, /256
    assign tap_now = {div_reg[7], div_reg[5], div_reg[3], div_reg[1]};
    assign tap_old = {div_prev_reg[7], div_prev_reg[5], div_prev_reg[3], div_prev_reg[1]};
    assign taps_o.rise = tap_now & ~tap_old;
    assign taps_o.fall = ~tap_now & tap_old;
endmodule : ttc_prescaler
`default_nettype wire

// *** tb/ttc_far_model.sv ***
// far-side model: channel pin, external clock pins and neighbour channel pulses
`timescale 1ns/1ns
`default_nettype none
module ttc_far_model (
    input wire logic clk_i,
    input wire logic pin_o_i,
    input wire logic pin_oe_i,
    output logic pin_i_o,
    output logic [1:0] ph_o,
    output logic [2:0] nb_o
);
    logic pin_lvl = 1'b0;
    // the wire follows the block while it drives, else our own level
    assign pin_i_o = pin_oe_i ? pin_o_i : pin_lvl;
    // clock pins start low and hold each stepped level until the next step, neighbour lines idle low
    initial begin
        ph_o = 2'h0;
        nb_o = 3'h0;
    end
    // one-cycle neighbour pulse: bit 0 overflow, bit 1 sync clear, bit 2 channel zero event
    task automatic nb_pulse(input logic [2:0] m);
        @(posedge clk_i);
        nb_o <= m;
        @(posedge clk_i);
        nb_o <= 3'h0;
        repeat (2) @(posedge clk_i);
    endtask : nb_pulse
    // held long enough for the two-stage synchroniser to see every level
    task automatic ph_step(input logic [1:0] v);
        @(posedge clk_i);
        ph_o <= v;
        repeat (4) @(posedge clk_i);
    endtask : ph_step
    task automatic pin_set(input logic v);
        @(posedge clk_i);
        pin_lvl <= v;
        repeat (4) @(posedge clk_i);
    endtask : pin_set
endmodule : ttc_far_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the timer channel one control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [2:0] a_ctl = ttc_pkg::ADDR_CTRL;
    localparam logic [2:0] a_mod = ttc_pkg::ADDR_MODE;
    localparam logic [2:0] a_io = ttc_pkg::ADDR_IOCTRL;
    localparam logic [2:0] a_cnt = ttc_pkg::ADDR_COUNTER;
    localparam logic [2:0] a_gra = ttc_pkg::ADDR_GRA;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [15:0] wr_data_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rd_data_o;
    logic pin_in;
    logic pin_out;
    logic pin_oe;
    logic [1:0] ph;
    logic [2:0] nb;
    logic ovf;
    logic syc;
    int err_count = 0;
    int num_checks = 0;
    // io rows: [7:4] code, [2] drives, [1] start level, [0] level after one match
    logic [7:0] io_rows [8] = '{8'h00, 8'h14, 8'h25, 8'h35, 8'h40, 8'h56, 8'h67, 8'h76};
    // edge rows: [15:8] control word, [7:0] count after three clock pulses
    logic [15:0] edge_rows [4] = '{16'h0403, 16'h0c03, 16'h1406, 16'h1c06};
    // quadrature steps, phase a leading phase b
    logic [7:0] qseq = 8'h2d;

    always #2 sys_clk_i = ~sys_clk_i;

    ttc_channel u_ttc_channel (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .channel_one_pin_a_i(pin_in), .clk_pin_a_i(ph[0]), .clk_pin_b_i(ph[1]),
        .neighbour_ovf_i(nb[0]), .sync_clear_i(nb[1]), .ch0_gra_event_i(nb[2]),
        .channel_one_pin_a_o(pin_out), .channel_one_pin_a_oe_o(pin_oe), .ovf_o(ovf),
        .sync_clear_o(syc));
    ttc_far_model u_ttc_far_model (.clk_i(sys_clk_i), .pin_o_i(pin_out), .pin_oe_i(pin_oe),
        .pin_i_o(pin_in), .ph_o(ph), .nb_o(nb));

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic check1(input string what, input logic seen, input logic exp);
        check(what, {15'h0000, seen}, {15'h0000, exp});
    endtask : check1
    // bus cycles: one-cycle strobes, changed just after the edge
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= v;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input string what, input logic [2:0] a, input logic [15:0] exp);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 check(what, rd_data_o, exp);
    endtask : rd_chk

    // watchdog so that a hang still reaches the verdict
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_count++;
        finish_test();
    end

    initial begin
        logic [3:0] c;
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd_chk("mode reset", a_mod, 16'h00c0);
        @(posedge sys_clk_i);
        #1 check("idle read data", rd_data_o, 16'h0000);
        rd_chk("io reset", a_io, 16'h0000);
        rd_chk("gra reset", a_gra, 16'hffff);
        // every mode code reads back with the fixed upper bits; top bit always written 0
        for (int i = 0; i < 8; i++) begin
            wr(a_mod, 16'(i));
            rd_chk("mode", a_mod, 16'h00c0 | 16'(i));
        end
        wr(a_mod, 16'h0000);
        // compare rows: counter frozen on a quiet pin while the code is set, then run at /1
        wr(a_ctl, 16'h0024);
        wr(a_gra, 16'h0009);
        foreach (io_rows[i]) begin
            c = io_rows[i][7:4];
            wr(a_io, {12'h000, c});
            #1 check1("drive", pin_oe, io_rows[i][2]);
            if (io_rows[i][2]) check1("start level", pin_out, io_rows[i][1]);
            wr(a_cnt, 16'h0000);
            wr(a_ctl, 16'h0020);
            repeat (13) @(posedge sys_clk_i);
            #1 if (io_rows[i][2]) check1("one match", pin_out, io_rows[i][0]);
            repeat (10) @(posedge sys_clk_i);
            #1 if (io_rows[i][2]) check1("two matches", pin_out,
                (c[1:0] == 2'h3) ? io_rows[i][1] : io_rows[i][0]);
            wr(a_ctl, 16'h0024);
        end
        wr(a_io, 16'h0000);
        // edge rows on the external clock pin
        foreach (edge_rows[i]) begin
            wr(a_ctl, {8'h00, edge_rows[i][15:8]});
            wr(a_cnt, 16'h0000);
            repeat (3) begin
                u_ttc_far_model.ph_step(2'h1);
                u_ttc_far_model.ph_step(2'h0);
            end
            rd_chk("edge count", a_cnt, {8'h00, edge_rows[i][7:0]});
        end
        // neighbour overflow source ignores a both-edges setting
        wr(a_ctl, 16'h001f);
        wr(a_cnt, 16'h0000);
        repeat (3) u_ttc_far_model.nb_pulse(3'h1);
        rd_chk("neighbour count", a_cnt, 16'h0003);
        // phase counting ignores the falling-edge setting: one full cycle counts four
        wr(a_mod, 16'h0004);
        wr(a_ctl, 16'h000c);
        wr(a_cnt, 16'h0000);
        for (int k = 0; k < 4; k++) u_ttc_far_model.ph_step(qseq[2*k +: 2]);
        rd_chk("phase count", a_cnt, 16'h0004);
        wr(a_mod, 16'h0000);
        // synchronous clear from a neighbour channel
        wr(a_ctl, 16'h0064);
        wr(a_cnt, 16'h0055);
        u_ttc_far_model.nb_pulse(3'h2);
        rd_chk("sync clear", a_cnt, 16'h0000);
        // pin capture: rising, falling, then both edges twice
        wr(a_ctl, 16'h0004);
        for (int k = 0; k < 4; k++) begin
            wr(a_io, 16'h0008 + 16'(k));
            wr(a_cnt, 16'h1230 + 16'(k));
            wr(a_gra, 16'h0000);
            u_ttc_far_model.pin_set(~k[0]);
            rd_chk("pin capture", a_gra, 16'h1230 + 16'(k));
        end
        // capture on the channel zero register a event
        wr(a_io, 16'h000c);
        wr(a_cnt, 16'h0abc);
        wr(a_gra, 16'h0000);
        u_ttc_far_model.nb_pulse(3'h4);
        rd_chk("event capture", a_gra, 16'h0abc);
        // undivided source wraps: fffe, ffff, then the overflow pulse stands one cycle
        wr(a_ctl, 16'h0000);
        wr(a_cnt, 16'hfffe);
        repeat (2) @(posedge sys_clk_i);
        #1 check1("overflow", ovf, 1'b1);
        // our own register A clear is exported once sync operation is on
        wr(a_io, 16'h0000);
        wr(3'h3, 16'h0001);
        wr(a_gra, 16'h0005);
        wr(a_cnt, 16'h0000);
        wr(a_ctl, 16'h0020);
        repeat (4) @(posedge sys_clk_i);
        #1 check1("sync clear out", syc, 1'b1);
        finish_test();
    end
endmodule : tb
`default_nettype wire
